// ==== verilog/csl_pkg.sv ====
// ============================================================
// Purpose: shared constants and helpers for the camera serial link framer
// Assumes: one system clock clk_sys at 200 MHz
// Notes:   register indices are word indices, byte address is four times
package csl_pkg;
	// ============================================================
	// frame layout
	localparam int FRAME_W  = 28;            // bits per forward frame
	localparam int PAY_W    = 26;            // scrambled payload bits
	localparam int DATA_W   = 24;            // data field in payload
	localparam int PAR_BIT  = 26;            // parity position
	localparam int INV_BIT  = 27;            // dc-balance inversion flag
	localparam int CVAL_BIT = 25;            // control bit valid
	localparam int CDAT_BIT = 24;            // control data bit
	localparam int BAL_MAX  = 13;            // most ones sent uninverted
	localparam int NEED10   = 24;            // data bits per frame, 10-bit
	localparam int NEED12   = 21;            // data bits per frame, 12-bit
	localparam int PIXW10   = 12;            // pixel + syncs, 10-bit
	localparam int PIXW12   = 14;            // pixel + syncs, 12-bit
	localparam int GPIO_N   = 4;             // general-purpose lines
	localparam int CRC_W    = 4;             // back channel crc bits
	localparam logic [30:0] LFSR_SEED = 31'h2b5a_1c3d; // scrambler start
	// ============================================================
	// timing
	localparam int CLK_MHZ        = 200;     // clk_sys rate
	localparam int BACK_PERIOD_NS = 4000;    // back channel word spacing
	localparam int BACK_CYC       = BACK_PERIOD_NS * CLK_MHZ / 1000;
	localparam int PCLK_LOSS_NS   = 200;     // pixel clock lost after
	localparam int PCLK_LOSS_CYC  = PCLK_LOSS_NS * CLK_MHZ / 1000;
	localparam int OSC_FRAME_NS   = 40;      // internal oscillator frame
	localparam int OSC_FRAME_CYC  = OSC_FRAME_NS * CLK_MHZ / 1000;
	// ============================================================
	// registers (word index)
	localparam logic [3:0] REG_CTRL  = 4'h3; // edge, mode, ext osc
	localparam logic [3:0] REG_GPO   = 4'h4; // local value, remote select
	localparam logic [3:0] REG_STAT  = 4'h5; // pclk present, ext osc
	localparam logic [3:0] REG_CRC_A = 4'ha; // crc error count low
	localparam logic [3:0] REG_CRC_B = 4'hb; // crc error count high
	localparam logic [2:0] CTRL_RST  = 3'h1; // rising edge, 10-bit, pclk
	localparam logic [7:0] GPO_RST   = 8'h00;
	// ============================================================
	// crc over the four line levels, x^4 + x + 1
	function automatic logic [3:0] csl_crc4(input logic [3:0] d);
		logic [3:0] c;
		c = 4'hf;
		for (int i = 3; i >= 0; i--)
		begin
			c = {c[2:0], 1'b0} ^ ((c[3] ^ d[i]) ? 4'h3 : 4'h0);
		end
		return c;
	endfunction : csl_crc4
	// count of ones in a payload
	function automatic logic [4:0] csl_ones(input logic [PAY_W-1:0] d);
		logic [4:0] n;
		n = 5'h00;
		for (int i = 0; i < PAY_W; i++)
		begin
			n = n + {4'h0, d[i]};
		end
		return n;
	endfunction : csl_ones
endpackage : csl_pkg

// ==== verilog/csl_link_if.sv ====
// ============================================================
// Purpose: forward frames and back channel words between the two ends
// Assumes: both ends on clk_sys
// Notes:   frame_video marks frames that carry pixels
`timescale 1ns/1ps
interface csl_link_if;
	logic [27:0] frame;        // forward frame
	logic        frame_valid;  // one-cycle frame strobe
	logic        frame_video;  // frame carries pixel data
	logic        line_high;    // line held static high
	logic [7:0]  bwd_word;     // {crc, line levels}
	logic        bwd_valid;    // one-cycle back word strobe
	modport link_transmitter (output frame, frame_valid, frame_video, line_high, input bwd_word, bwd_valid);
	modport des (input frame, frame_valid, frame_video, line_high, output bwd_word, bwd_valid);
endinterface : csl_link_if

// ==== verilog/csl_scrambler.sv ====
// ============================================================
// Purpose: payload scrambling mask, stepped once per frame
// Assumes: both ends step on the same frames from the same reset
// Notes:   additive, so the same mask descrambles
`timescale 1ns/1ps
module csl_scrambler (
	input  wire logic                      clk_sys, // system clock
	input  wire logic                      rst,     // sync reset
	input  wire logic                      step,    // advance one frame
	output logic [csl_pkg::PAY_W-1:0]      mask     // current mask
);
	import csl_pkg::*;
	logic [30:0] lfsr_ff;
	// advance a full payload of bits, x^31 + x^28 + 1
	function automatic logic [30:0] csl_adv(input logic [30:0] s);
		logic [30:0] t;
		t = s;
		for (int i = 0; i < PAY_W; i++)
		begin
			t = {t[29:0], t[30] ^ t[27]};
		end
		return t;
	endfunction : csl_adv
	// ============================================================
	// state
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			lfsr_ff <= LFSR_SEED;
		else if (step)
			lfsr_ff <= csl_adv(lfsr_ff);
	end
	assign mask = lfsr_ff[PAY_W-1:0];
endmodule : csl_scrambler

// ==== verilog/csl_serializer.sv ====
// ============================================================
// Purpose: camera-side framer, packs pixels into 28-bit scrambled frames
// Assumes: pixel clock edges arrive as one-cycle pix_rise/pix_fall pulses
// Notes:   registers over Avalon-MM, one wait state on every access
// Contract
// - 12-bit mode takes 12 data plus 2 syncs
// - 10-bit mode takes 10 data plus 2 syncs
// - imager changes syncs at most once per 10
// - frame is 28 bits with data, control, parity
// - payload scrambled and dc balanced per mode
// - control bits ride every frame, both directions; back words here carry only line levels and crc
// - frame rate is pixel clock /2 or /1.5
// - 28 bits sent per frame clock
// - forward parity bit, back channel 4-bit crc
// - back channel crc errors counted, two registers
// - far end counts parity errors, clear on read
// - forwarded line arrives within 32 us
// - skew between links within 23 us
// - output may follow remote line level
// - output may follow local register bit
// - no serializer line forwarded to far end
// - ext osc mode: pin 3 in, pin 2 divided
// - ext osc mode: far pins 2,3 local only
// - forwarded lines supported up to 66 kHz
// - edge select picks rising or falling sample
// - power down holds line static high
// - pixel clock lost: run internal oscillator
`timescale 1ns/1ps
module csl_serializer (
	input  wire logic                        clk_sys,              // system clock
	input  wire logic                        rst,                  // sync reset
	input  wire logic [5:0]                  avs_address,          // byte address
	input  wire logic                        avs_read,             // read request
	input  wire logic                        avs_write,            // write request
	input  wire logic [31:0]                 avs_writedata,        // write data
	output logic [31:0]                      avs_readdata,         // read data
	output logic                             avs_waitrequest,      // stall
	input  wire logic [11:0]                 pixel_data,           // pixel bits
	input  wire logic                        horizontal_sync_in,   // line sync
	input  wire logic                        vertical_sync_in,     // frame sync
	input  wire logic                        pix_rise,             // pixel clock rise
	input  wire logic                        pix_fall,             // pixel clock fall
	input  wire logic                        power_down_n,         // low: power down
	input  wire logic                        ext_osc_clock_in,     // oscillator level
	input  wire logic [7:0]                  fwd_ctrl_byte,        // control byte
	input  wire logic                        fwd_ctrl_valid,       // byte offered
	output logic                             fwd_ctrl_ready,       // byte taken
	output logic [csl_pkg::GPIO_N-1:0]       general_output_pin,   // output levels
	output logic [csl_pkg::GPIO_N-1:0]       general_output_oe,    // output enables
	output logic                             divided_ref_clock_out,// imager reference
	csl_link_if.link_transmitter                          link                  // serial side
);
	import csl_pkg::*;
	logic [2:0]          ctrl_ff;      // [0] edge, [1] 12-bit, [2] ext osc
	logic [7:0]          gpo_ff;       // [3:0] local, [7:4] remote select
	logic [GPIO_N-1:0]   remote_ff;
	logic [15:0]         crc_err_ff;
	logic [41:0]         acc_ff, nxt_acc;
	logic [7:0]          pclk_age_ff, osc_cnt_ff, csh_ff;
	logic [5:0]          cnt_ff, nxt_cnt, need;
	logic [3:0]          cleft_ff, idx;
	logic [DATA_W-1:0]   data;
	logic [PAY_W-1:0]    payload, scr, mask;
	logic                ack_ff, osc_prev_ff, div_ff, take, bal;
	logic                pstb, vid_emit, idle_emit, emit, pclk_ok;
	wire  logic          mode12 = ctrl_ff[1];
	wire  logic          extosc = ctrl_ff[2];
	assign idx  = avs_address[5:2];
	assign take = (avs_read || avs_write) && avs_waitrequest && !ack_ff;
	// ============================================================
	// register bus
	// one wait state, request taken when waitrequest drops
	always_ff @(posedge clk_sys)
	begin
		ack_ff          <= rst ? 1'b0 : take;
		avs_waitrequest <= rst ? 1'b1 : !take;
	end
	// read data, unmapped reads zero
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			avs_readdata <= 32'h0;
		else if (take && avs_read)
		begin
			if (idx == REG_CTRL)
				avs_readdata <= {29'h0, ctrl_ff};
			else if (idx == REG_GPO)
				avs_readdata <= {24'h0, gpo_ff};
			else if (idx == REG_STAT)
				avs_readdata <= {30'h0, extosc, pclk_ok};
			else if (idx == REG_CRC_A)
				avs_readdata <= {24'h0, crc_err_ff[7:0]};
			else if (idx == REG_CRC_B)
				avs_readdata <= {24'h0, crc_err_ff[15:8]};
			else
				avs_readdata <= 32'h0;
		end
	end
	// writes land on the edge where waitrequest is seen low
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			ctrl_ff <= CTRL_RST;
			gpo_ff  <= GPO_RST;
		end
		else if (avs_write && !avs_waitrequest)
		begin
			if (idx == REG_CTRL)
				ctrl_ff <= avs_writedata[2:0];
			else if (idx == REG_GPO)
				gpo_ff <= avs_writedata[7:0];
		end
	end
	// ============================================================
	// pixel sampling and packing
	assign pstb = power_down_n && (ctrl_ff[0] ? pix_rise : pix_fall);
	assign need = mode12 ? 6'(NEED12) : 6'(NEED10);
	// append one pixel word, cut a frame when enough bits wait
	always_comb
	begin
		nxt_acc  = acc_ff;
		nxt_cnt  = cnt_ff;
		data     = '0;
		vid_emit = 1'b0;
		if (pstb)
		begin
			if (mode12)
				nxt_acc = acc_ff | (42'({vertical_sync_in, horizontal_sync_in,
					pixel_data}) << cnt_ff);
			else
				nxt_acc = acc_ff | (42'({vertical_sync_in, horizontal_sync_in,
					pixel_data[9:0]}) << cnt_ff);
			nxt_cnt = cnt_ff + (mode12 ? 6'(PIXW12) : 6'(PIXW10));
		end
		// 24 bits per frame: /2 in 10-bit, 21 bits: /1.5 in 12-bit
		if (nxt_cnt >= need)
		begin
			vid_emit = 1'b1;
			data     = mode12 ? {3'h0, nxt_acc[NEED12-1:0]} : nxt_acc[DATA_W-1:0];
			nxt_acc  = nxt_acc >> need;
			nxt_cnt  = nxt_cnt - need;
		end
	end
	always_ff @(posedge clk_sys)
	begin
		acc_ff <= (rst || !power_down_n) ? '0 : nxt_acc;
		cnt_ff <= (rst || !power_down_n) ? 6'h0 : nxt_cnt;
	end
	// ============================================================
	// pixel clock watch and internal oscillator frames
	assign pclk_ok   = pclk_age_ff < 8'(PCLK_LOSS_CYC);
	assign idle_emit = !pclk_ok && osc_cnt_ff == 8'(OSC_FRAME_CYC - 1);
	assign emit      = power_down_n && (vid_emit || idle_emit);
	always_ff @(posedge clk_sys)
	begin
		if (rst || pix_rise || pix_fall)
			pclk_age_ff <= 8'h0;
		else if (pclk_ok)
			pclk_age_ff <= pclk_age_ff + 8'h1;
	end
	always_ff @(posedge clk_sys)
	begin
		osc_cnt_ff <= (rst || pclk_ok || idle_emit) ? 8'h0 : osc_cnt_ff + 8'h1;
	end
	// ============================================================
	// forward control bits, one per frame
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			csh_ff         <= 8'h0;
			cleft_ff       <= 4'h0;
			fwd_ctrl_ready <= 1'b1;
		end
		else if (fwd_ctrl_valid && fwd_ctrl_ready)
		begin
			csh_ff         <= fwd_ctrl_byte;
			cleft_ff       <= 4'h8;
			fwd_ctrl_ready <= 1'b0;
		end
		else if (emit && cleft_ff != 4'h0)
		begin
			csh_ff         <= {1'b0, csh_ff[7:1]};
			cleft_ff       <= cleft_ff - 4'h1;
			fwd_ctrl_ready <= cleft_ff == 4'h1;                  // free after last bit
		end
	end
	// ============================================================
	// frame build: scramble, balance, parity
	assign payload = {cleft_ff != 4'h0, csh_ff[0], data};
	assign scr     = payload ^ mask;
	assign bal     = csl_ones(scr) > 5'(BAL_MAX);
	csl_scrambler u_scr (
		.clk_sys (clk_sys),
		.rst     (rst),
		.step    (emit),
		.mask    (mask)
	);
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			link.frame       <= '0;
			link.frame_valid <= 1'b0;
			link.frame_video <= 1'b0;
		end
		else
		begin
			link.frame_valid <= emit;
			if (emit)
			begin
				link.frame_video <= vid_emit;
				link.frame       <= {bal, ^payload, bal ? ~scr : scr};
			end
		end
	end
	always_ff @(posedge clk_sys)
	begin
		link.line_high <= rst || !power_down_n;
	end
	// ============================================================
	// back channel: crc check and remote levels
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			crc_err_ff <= 16'h0;
			remote_ff  <= '0;
		end
		else if (link.bwd_valid)
		begin
			if (csl_crc4(link.bwd_word[3:0]) != link.bwd_word[7:4])
				crc_err_ff <= crc_err_ff + 16'h1;
			else
				remote_ff <= link.bwd_word[3:0];
		end
	end
	// ============================================================
	// outputs: local or remote, oscillator pins in ext osc mode
	always_ff @(posedge clk_sys)
	begin
		osc_prev_ff <= !rst && ext_osc_clock_in;
		if (rst)
			div_ff <= 1'b0;
		else if (extosc && ext_osc_clock_in && !osc_prev_ff)
			div_ff <= !div_ff;
	end
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			general_output_pin    <= '0;
			general_output_oe     <= '0;
			divided_ref_clock_out <= 1'b0;
		end
		else
		begin
			for (int i = 0; i < GPIO_N; i++)
			begin
				general_output_pin[i] <= gpo_ff[4+i] ? remote_ff[i]
					: gpo_ff[i];
			end
			general_output_oe <= extosc ? 4'h7 : 4'hf;            // pin 3 input
			if (extosc)
				general_output_pin[2] <= div_ff;
			divided_ref_clock_out <= extosc && div_ff;
		end
	end
endmodule : csl_serializer

// ==== verilog/csl_deserializer.sv ====
// ============================================================
// Purpose: far-end receiver, unpacks frames, sends line levels back
// Assumes: mode_12bit matches the serializer setting
// Notes:   pixel words leave one per cycle as they complete
`timescale 1ns/1ps
module csl_deserializer (
	input  wire logic                  clk_sys,         // system clock
	input  wire logic                  rst,             // sync reset
	csl_link_if.des                    link,            // serial side
	input  wire logic                  mode_12bit,      // 12-bit mode
	input  wire logic                  ext_osc_mode,    // ext oscillator mode
	input  wire logic [3:0]            gpio_in,         // forwarded line levels
	output logic [11:0]                pixel_out,       // pixel bits
	output logic                       hsync_out,       // line sync
	output logic                       vsync_out,       // frame sync
	output logic                       pixel_valid,     // pixel strobe
	output logic [7:0]                 ctrl_byte_out,   // control byte
	output logic                       ctrl_byte_valid, // byte strobe
	output logic [7:0]                 parity_err_lo,   // parity count low
	output logic [7:0]                 parity_err_hi,   // parity count high
	input  wire logic                  parity_err_read  // clears the count
);
	import csl_pkg::*;
	logic [55:0]        acc_ff;
	logic [5:0]         cnt_ff;
	logic [7:0]         csh_ff;
	logic [2:0]         cnum_ff;
	logic [15:0]        perr_ff;
	logic [11:0]        bcnt_ff;
	logic [55:0]        nxt_acc;
	logic [5:0]         nxt_cnt;
	logic [PAY_W-1:0]   mask;
	logic [PAY_W-1:0]   raw;
	logic [5:0]         pw;
	logic               perr;
	logic [3:0]         lv;
	assign raw  = (link.frame[INV_BIT] ? ~link.frame[PAY_W-1:0] : link.frame[PAY_W-1:0]) ^ mask;
	assign perr = link.frame_valid && (^raw != link.frame[PAR_BIT]);
	assign pw   = mode_12bit ? 6'(PIXW12) : 6'(PIXW10);
	csl_scrambler u_scr (
		.clk_sys (clk_sys),
		.rst     (rst),
		.step    (link.frame_valid),
		.mask    (mask)
	);
	// ============================================================
	// unpack: append frame data, drop one pixel per cycle
	always_comb
	begin
		nxt_acc = acc_ff;
		nxt_cnt = cnt_ff;
		if (cnt_ff >= pw)
		begin
			nxt_acc = acc_ff >> pw;
			nxt_cnt = cnt_ff - pw;
		end
		if (link.frame_valid && link.frame_video)
		begin
			nxt_acc = nxt_acc | (56'(mode_12bit ? {3'h0, raw[NEED12-1:0]}
				: raw[DATA_W-1:0]) << nxt_cnt);
			nxt_cnt = nxt_cnt + (mode_12bit ? 6'(NEED12) : 6'(NEED10));
		end
	end
	always_ff @(posedge clk_sys)
	begin
		if (rst || link.line_high)
		begin
			acc_ff <= '0;
			cnt_ff <= 6'h0;
		end
		else
		begin
			acc_ff <= nxt_acc;
			cnt_ff <= nxt_cnt;
		end
	end
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			pixel_out   <= 12'h0;
			hsync_out   <= 1'b0;
			vsync_out   <= 1'b0;
			pixel_valid <= 1'b0;
		end
		else
		begin
			pixel_valid <= cnt_ff >= pw;
			if (cnt_ff >= pw)
			begin
				pixel_out <= mode_12bit ? acc_ff[11:0] : {2'h0, acc_ff[9:0]};
				hsync_out <= mode_12bit ? acc_ff[12] : acc_ff[10];
				vsync_out <= mode_12bit ? acc_ff[13] : acc_ff[11];
			end
		end
	end
	// ============================================================
	// forward control bits, lsb first
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			csh_ff          <= 8'h0;
			cnum_ff         <= 3'h0;
			ctrl_byte_out   <= 8'h0;
			ctrl_byte_valid <= 1'b0;
		end
		else
		begin
			ctrl_byte_valid <= 1'b0;
			if (link.frame_valid && raw[CVAL_BIT])
			begin
				csh_ff  <= {raw[CDAT_BIT], csh_ff[7:1]};
				cnum_ff <= cnum_ff + 3'h1;
				if (cnum_ff == 3'h7)
				begin
					ctrl_byte_out   <= {raw[CDAT_BIT], csh_ff[7:1]};
					ctrl_byte_valid <= 1'b1;
				end
			end
		end
	end
	// ============================================================
	// parity errors since lock or last read, a new error wins the clear
	always_ff @(posedge clk_sys)
	begin
		if (rst || link.line_high)
			perr_ff <= 16'h0;
		else if (parity_err_read)
			perr_ff <= {15'h0, perr};
		else if (perr)
			perr_ff <= perr_ff + 16'h1;
	end
	assign parity_err_lo = perr_ff[7:0];
	assign parity_err_hi = perr_ff[15:8];
	// ============================================================
	// back channel: levels plus crc every few microseconds
	assign lv = ext_osc_mode ? {2'b00, gpio_in[1:0]} : gpio_in;
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			bcnt_ff        <= 12'h0;
			link.bwd_valid <= 1'b0;
			link.bwd_word  <= 8'h0;
		end
		else
		begin
			link.bwd_valid <= bcnt_ff == 12'(BACK_CYC - 1);
			bcnt_ff        <= (bcnt_ff == 12'(BACK_CYC - 1)) ? 12'h0 : bcnt_ff + 12'h1;
			if (bcnt_ff == 12'(BACK_CYC - 1))
				link.bwd_word <= {csl_crc4(lv), lv};
		end
	end
endmodule : csl_deserializer

// ==== bench/csl_link_sva.sv ====
// ====
// Purpose: link checks between the two ends
// Assumes: one clock, sync reset
// Notes:   sees link signals only
`timescale 1ns/1ps
module csl_link_sva (
	input wire logic        clk_sys,     // clock
	input wire logic        rst,         // reset
	input wire logic [27:0] frame,       // frame
	input wire logic        frame_valid, // strobe
	input wire logic        frame_video, // pixels
	input wire logic        line_high,   // idle high
	input wire logic [7:0]  bwd_word,    // back word
	input wire logic        bwd_valid    // back strobe
);
	localparam int BWD_MAX = 800;
	localparam int OSC_MAX = 20; // idle spacing plus two slow pixels on clock return
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// crc of line levels
	function automatic logic [3:0] crc_ref(input logic [3:0] d);
		logic [3:0] c;
		c = 4'hf;
		for (int i = 3; i >= 0; i--)
			c = {c[2:0], 1'b0} ^ {2'h0, {2{c[3] ^ d[i]}}};
		return c;
	endfunction : crc_ref
	// ====
	// checks
	AST_PD_QUIET:
		assert property (line_high |-> !frame_valid) else $error("frame in power down");
	AST_FRAME_HOLD:
		assert property (!frame_valid && !$past(rst) && !(line_high || $past(line_high))
			|-> $stable(frame)) else $error("frame moved");
	AST_FRAME_GAP:
		assert property (frame_valid |=> !frame_valid) else $error("frames adjacent");
	AST_BALANCE:
		assert property (frame_valid |-> $countones(frame[25:0]) <= 13) else $error("unbalanced");
	AST_IDLE_RATE:
		assert property (frame_valid && !frame_video |-> ##[1:OSC_MAX] (frame_valid || line_high))
		else $error("idle frame late");
	AST_IDLE_SPACE:
		assert property (frame_valid && !frame_video |=> !(frame_valid && !frame_video) [*7])
		else $error("idle frames too close");
	AST_BWD_GAP:
		assert property (bwd_valid |=> !bwd_valid [*8]) else $error("back words adjacent");
	AST_BWD_EVERY:
		assert property (bwd_valid |-> ##[1:BWD_MAX] bwd_valid) else $error("back word late");
	AST_BWD_CRC:
		assert property (bwd_valid |-> bwd_word[7:4] == crc_ref(bwd_word[3:0])) else $error("bad crc");
	// main scenarios
	COV_VIDEO: cover property (frame_valid && frame_video);
	COV_IDLE: cover property (frame_valid && !frame_video);
	COV_BWD: cover property (bwd_valid);
endmodule : csl_link_sva

// ==== bench/test_camera_serializer_link_framing.sv ====
// ====
// Purpose: serializer facing deserializer
// Assumes: pixel edges as one-cycle pulses
// Notes:   lfsr pixels plus hand cases
`timescale 1ns/1ps
module test_camera_serializer_link_framing;
	logic        clk_sys = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, d0;
	logic [5:0]  avs_address = 6'h00;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rd, lfsr = 32'h80db;
	logic [11:0] pixel_data = 12'h000, pixel_out;
	logic [7:0]  fwd_ctrl_byte = 8'h00, ctrl_byte_out, parity_err_lo, parity_err_hi, cb_exp;
	logic [3:0]  gpio_in = 4'h0, general_output_pin, general_output_oe;
	logic [1:0]  syn = 2'h0;
	logic [13:0] q[$];
	logic        horizontal_sync_in = 1'b0, vertical_sync_in = 1'b0, pix_rise = 1'b0;
	logic        pix_fall = 1'b0, power_down_n = 1'b1, ext_osc_clock_in = 1'b0;
	logic        fwd_ctrl_valid = 1'b0, mode_12bit = 1'b0, ext_osc_mode = 1'b0;
	logic        parity_err_read = 1'b0, avs_waitrequest, fwd_ctrl_ready, divided_ref_clock_out;
	logic        hsync_out, vsync_out, pixel_valid, ctrl_byte_valid;
	int          errors = 0, n_tests = 0, cyc = 0, pc = 0, n_cb = 0;
	csl_link_if lk ();
	csl_serializer csl_serializer_inst (.clk_sys, .rst, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_readdata, .avs_waitrequest, .pixel_data, .horizontal_sync_in,
		.vertical_sync_in, .pix_rise, .pix_fall, .power_down_n, .ext_osc_clock_in,
		.fwd_ctrl_byte, .fwd_ctrl_valid, .fwd_ctrl_ready, .general_output_pin,
		.general_output_oe, .divided_ref_clock_out, .link(lk));
	csl_deserializer csl_deserializer_inst (.clk_sys, .rst, .link(lk), .mode_12bit,
		.ext_osc_mode, .gpio_in, .pixel_out, .hsync_out, .vsync_out, .pixel_valid,
		.ctrl_byte_out, .ctrl_byte_valid, .parity_err_lo, .parity_err_hi, .parity_err_read);
	csl_link_sva csl_link_sva_inst (.clk_sys, .rst, .frame(lk.frame),
		.frame_valid(lk.frame_valid), .frame_video(lk.frame_video), .line_high(lk.line_high),
		.bwd_word(lk.bwd_word), .bwd_valid(lk.bwd_valid));
	// ====
	// helpers
	always #2.5 clk_sys = ~clk_sys;
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nxt
	function automatic logic [13:0] exp_word(input logic [13:0] w);
		return mode_12bit ? w : w & 14'h33ff;
	endfunction : exp_word
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		n_tests++;
		if (seen !== want)
		begin
			errors++;
			$display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask : check
	task automatic final_report;
		$display("errors=%0d n_tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : final_report
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0)
			@(posedge clk_sys);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk_sys);
	endtask : bus
	// taken edge carries the pixel, the other edge junk
	task automatic pixels(input int n, input logic fall);
		repeat (n)
		begin
			lfsr = nxt(lfsr);
			if (pc % 10 == 0)
				syn = lfsr[13:12];
			pc++;
			{vertical_sync_in, horizontal_sync_in, pixel_data} <= {syn, lfsr[11:0]};
			q.push_back(exp_word({syn, lfsr[11:0]}));
			{pix_rise, pix_fall} <= {!fall, fall};
			@(posedge clk_sys);
			{pix_rise, pix_fall} <= 2'b00;
			@(posedge clk_sys);
			pixel_data <= ~lfsr[11:0];
			{pix_rise, pix_fall} <= {fall, !fall};
			@(posedge clk_sys);
			{pix_rise, pix_fall} <= 2'b00;
			@(posedge clk_sys);
		end
	endtask : pixels
	// far end monitor and hang guard
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		if (pixel_valid === 1'b1)
			check(exp_word({vsync_out, hsync_out, pixel_out}), q.size() ? q.pop_front() : 32'hx);
		if (ctrl_byte_valid === 1'b1)
		begin
			check(ctrl_byte_out, cb_exp);
			n_cb <= n_cb + 1;
		end
		if (cyc == 20000)
		begin
			errors++;
			final_report();
		end
	end
	// ====
	// main sequence
	initial
	begin
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		bus(1'b0, 6'h0c, 32'h0);
		check(rd, 32'h1);
		bus(1'b1, 6'h28, 32'hff);
		bus(1'b0, 6'h28, 32'h0);
		check(rd, 32'h0);
		bus(1'b0, 6'h3c, 32'h0);
		check(rd, 32'h0);
		lfsr = nxt(lfsr);
		cb_exp = lfsr[7:0];
		fwd_ctrl_byte <= cb_exp;
		fwd_ctrl_valid <= 1'b1;
		@(posedge clk_sys);
		while (fwd_ctrl_ready !== 1'b1)
			@(posedge clk_sys);
		fwd_ctrl_valid <= 1'b0;
		pixels(40, 1'b0);
		repeat (60) @(posedge clk_sys);
		check(32'(q.size()), 32'h0);
		check(n_cb, 32'h1);
		bus(1'b0, 6'h14, 32'h0);
		check(rd[0], 1'b0);
		bus(1'b1, 6'h0c, 32'h2);
		mode_12bit <= 1'b1;
		@(posedge clk_sys);
		pixels(30, 1'b1);
		repeat (60) @(posedge clk_sys);
		check(32'(q.size()), 32'h0);
		check({parity_err_hi, parity_err_lo}, 32'h0);
		bus(1'b1, 6'h10, 32'h0a);
		repeat (2) @(posedge clk_sys);
		check(general_output_pin, 4'ha);
		check(general_output_oe, 4'hf);
		lfsr = nxt(lfsr);
		gpio_in <= lfsr[3:0];
		bus(1'b1, 6'h10, 32'hf0);
		repeat (1700) @(posedge clk_sys);
		check(general_output_pin, gpio_in);
		bus(1'b0, 6'h2c, 32'h0);
		check(rd, 32'h0);
		power_down_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
		check(lk.line_high, 1'b1);
		power_down_n <= 1'b1;
		bus(1'b1, 6'h0c, 32'h5);
		ext_osc_mode <= 1'b1;
		repeat (3) @(posedge clk_sys);
		check(general_output_oe, 4'h7);
		d0 = divided_ref_clock_out;
		ext_osc_clock_in <= 1'b1;
		repeat (2) @(posedge clk_sys);
		ext_osc_clock_in <= 1'b0;
		repeat (3) @(posedge clk_sys);
		check(divided_ref_clock_out, !d0);
		final_report();
	end
endmodule : test_camera_serializer_link_framing
